/* File: verilog/eis_pkg.sv */
// Shared constants and carriers for the ethernet interrupt status block
package eis_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0]  EIS_ADDR_STATUS    = 8'h58;
   localparam logic [7:0]  EIS_ADDR_ENABLE    = 8'h5c;
   localparam logic [7:0]  EIS_ADDR_BYTE_TEST = 8'h64;
   localparam logic [7:0]  EIS_ADDR_LEVELS    = 8'h68;

   ////////////////////////////////////////////////////////////////////////////
   // Flag positions in interrupt_status and the enable register
   localparam int EIS_BIT_SOFTWARE  = 31;
   localparam int EIS_BIT_TX_HALT   = 25;
   localparam int EIS_BIT_RX_HALT   = 24;
   localparam int EIS_BIT_DROP_MID  = 23;
   localparam int EIS_BIT_TX_DONE   = 21;
   localparam int EIS_BIT_RX_DMA    = 20;
   localparam int EIS_BIT_TIMER     = 19;
   localparam int EIS_BIT_PHY       = 18;
   localparam int EIS_BIT_WAKE      = 17;
   localparam int EIS_BIT_TXS_OVF   = 16;
   localparam int EIS_BIT_OVERSIZE  = 15;
   localparam int EIS_BIT_RX_FAULT  = 14;
   localparam int EIS_BIT_TX_FAULT  = 13;
   localparam int EIS_BIT_TXD_OVR   = 10;
   localparam int EIS_BIT_TXD_SPACE = 9;
   localparam int EIS_BIT_TXS_FULL  = 8;
   localparam int EIS_BIT_TXS_LEVEL = 7;
   localparam int EIS_BIT_DISCARD   = 6;
   localparam int EIS_BIT_RXS_FULL  = 4;
   localparam int EIS_BIT_RXS_LEVEL = 3;
   localparam int EIS_BIT_PIN_LO    = 0;
   localparam int EIS_PIN_COUNT     = 3;

   // Write-one-to-clear flags; the transceiver bit and reserved bits are excluded
   localparam logic [31:0] EIS_W1C_MASK    = 32'h83bb_e7df;
   localparam logic [31:0] EIS_ENABLE_MASK = 32'h83ff_e7df;

   ////////////////////////////////////////////////////////////////////////////
   // Threshold register layout and reset
   localparam int          EIS_LVL_TXSPACE_LO = 24;
   localparam int          EIS_LVL_TXSTAT_LO  = 16;
   localparam int          EIS_LVL_RXSTAT_LO  = 0;
   localparam int          EIS_LVL_WIDTH      = 8;
   localparam logic [31:0] EIS_LEVELS_MASK    = 32'hffff_00ff;
   localparam logic [31:0] EIS_LEVELS_RESET   = 32'h4800_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Misc values
   localparam logic [31:0] EIS_BYTE_TEST_VALUE = 32'h8765_4321;
   localparam logic [15:0] EIS_OVERSIZE_BYTES  = 16'h0800;
   localparam logic [15:0] EIS_TIMER_ZERO      = 16'h0000;
   localparam logic [15:0] EIS_TIMER_WRAP      = 16'hffff;
   localparam logic [1:0]  EIS_HTRANS_NONSEQ   = 2'b10;
   localparam logic        EIS_HRESP_OKAY      = 1'b0;
   localparam logic [31:0] EIS_ZERO_WORD       = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Event sources, all from logic on clk
   typedef struct packed {
      logic        tx_stop_requested;
      logic        tx_halted;
      logic        rx_halted;
      logic        drop_count_msb;
      logic        tx_buffer_loaded;
      logic        buffer_completion_marker;
      logic        rx_dma_count_done;
      logic [15:0] timer_count;
      logic        wake_event;
      logic        tx_status_push;
      logic        tx_status_full;
      logic        rx_packet_end;
      logic [15:0] rx_packet_bytes;
      logic        rx_fault;
      logic        tx_fault;
      logic        tx_data_write;
      logic        tx_data_full;
      logic [7:0]  tx_free_blocks;
      logic [7:0]  tx_status_used;
      logic [7:0]  rx_status_used;
      logic        rx_status_full;
      logic        frame_discarded;
      logic [2:0]  pin_events;
   } eis_event_type;

endpackage : eis_pkg

/* File: verilog/eis_status.sv */
// Interrupt status collection with its AHB-Lite register slave
//
// Overview of operation
// RULE_01: Writing one clears a flag; writing zero leaves it untouched.
// RULE_02: Software flag sets when the software trigger enable rises; stays until cleared.
// RULE_03: Transmit-halted flag sets when stop is requested and transmitter is halted.
// RULE_04: Receive-halted flag sets once the receiver halts.
// RULE_05: Drop-counter midpoint flag sets when the counter top bit rises.
// RULE_06: Transmit-done flag sets when a marked buffer finishes loading.
// RULE_07: Receive DMA flag sets when the programmed word count has been read.
// RULE_08: Timer flag sets when the timer wraps from zero to all ones.
// RULE_09: Transceiver bit is read-only and follows the transceiver interrupt.
// RULE_10: Wake-event flag sets on any wake event; write one clears it unless a wake event comes in the same cycle.
// RULE_11: Wake events never leave low power; only a byte-test write does.
// RULE_12: Wake-event interrupt bypasses the deassertion hold-off interval.
// RULE_13: Status overflow flag sets when a status word meets a full FIFO.
// RULE_14: Oversize flag sets when a received packet exceeds 2048 bytes.
// RULE_15: Receiver fault flag sets on any receive engine error.
// RULE_16: Transmitter fault flag sets on any transmit engine error.
// RULE_17: Data overrun flag sets on a write into a full transmit data FIFO.
// RULE_18: Space flag sets when transmit free space exceeds its threshold.
// RULE_19: Bit 8 sets on transmit status full, bit 7 on level threshold.
// RULE_20: Discard flag sets each time a receive frame is dropped.
// RULE_21: Bit 4 sets on receive status full, bit 3 on level threshold.
// RULE_22: Bits 2 to 0 hold one clearable flag per pin event.
// RULE_23: Flags record events regardless of their enable bits.
// RULE_24: Master indicator is high while any enabled flag is set.
// RULE_25: Level and space events fire on strictly greater than threshold.
// RULE_26: An event in the same cycle as its clear keeps the flag set.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/10ps

module eis_status
   import eis_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic               hreadyout,
   output logic               hresp,
   output logic [31:0]        hrdata,
   input  wire eis_event_type events,
   input  wire logic          transceiver_irq_pin,
   output logic               master_irq_q,
   output logic               wake_irq_q,
   output logic               wake_request_q
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [31:0] status_q;
   logic [31:0] status_d;
   logic [31:0] enable_q;
   logic [31:0] levels_q;
   logic [31:0] set_v;
   logic [31:0] clr_v;
   logic [7:0]  addr_q;
   logic        wr_pend_q;
   logic        rd_sel;
   logic        wr_status;
   logic        wr_enable;
   logic        wr_byte_test;
   logic        wr_levels;
   logic        phy_meta_q;
   logic        phy_sync_q;
   logic [8:0]  lvl_now;
   logic [8:0]  lvl_prev_q;
   logic [8:0]  lvl_rise;
   logic        timer_zero_q;
   logic [31:0] read_mux;

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, writes land in the data phase
   assign rd_sel = hsel && hready && (htrans == EIS_HTRANS_NONSEQ) && !hwrite;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else begin
         if (hready) begin
            wr_pend_q <= hsel && (htrans == EIS_HTRANS_NONSEQ) && hwrite;
            addr_q    <= haddr[7:0];
         end
      end
   end

   assign wr_status    = wr_pend_q && (addr_q == EIS_ADDR_STATUS);
   assign wr_enable    = wr_pend_q && (addr_q == EIS_ADDR_ENABLE);
   assign wr_byte_test = wr_pend_q && (addr_q == EIS_ADDR_BYTE_TEST);
   assign wr_levels    = wr_pend_q && (addr_q == EIS_ADDR_LEVELS);

   // Unmapped offsets read as zero and ignore writes
   always_comb begin
      unique case (haddr[7:0])
         EIS_ADDR_STATUS:    read_mux = status_q;
         EIS_ADDR_ENABLE:    read_mux = enable_q;
         EIS_ADDR_BYTE_TEST: read_mux = EIS_BYTE_TEST_VALUE;
         EIS_ADDR_LEVELS:    read_mux = levels_q;
         default:            read_mux = EIS_ZERO_WORD;
      endcase
   end

   // Read data is captured at the address phase so it leaves a flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata    <= EIS_ZERO_WORD;
         hreadyout <= 1'b1;
         hresp     <= EIS_HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= EIS_HRESP_OKAY;
         if (rd_sel) begin
            hrdata <= read_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers: enables and thresholds
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enable_q <= EIS_ZERO_WORD;
      end else if (wr_enable) begin
         enable_q <= hwdata & EIS_ENABLE_MASK;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         levels_q <= EIS_LEVELS_RESET;
      end else if (wr_levels) begin
         levels_q <= hwdata & EIS_LEVELS_MASK;
      end
   end

   // Wake only by a byte-test write, never by a detected wake event
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_request_q <= 1'b0;
      end else begin
         wake_request_q <= wr_byte_test; // [RULE_11]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transceiver interrupt pin synchroniser
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phy_meta_q <= 1'b0;
         phy_sync_q <= 1'b0;
      end else begin
         phy_meta_q <= transceiver_irq_pin;
         phy_sync_q <= phy_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Level sources set their flag on the rising edge only, so a level that
   // stays high cannot refill a flag the host just cleared
   assign lvl_now[0] = enable_q[EIS_BIT_SOFTWARE];
   assign lvl_now[1] = events.tx_stop_requested && events.tx_halted;
   assign lvl_now[2] = events.rx_halted;
   assign lvl_now[3] = events.drop_count_msb;
   assign lvl_now[4] = events.tx_status_full;
   assign lvl_now[5] = events.rx_status_full;
   assign lvl_now[6] = events.tx_free_blocks >
                       levels_q[EIS_LVL_TXSPACE_LO +: EIS_LVL_WIDTH]; // [RULE_25]
   assign lvl_now[7] = events.tx_status_used >
                       levels_q[EIS_LVL_TXSTAT_LO +: EIS_LVL_WIDTH];  // [RULE_25]
   assign lvl_now[8] = events.rx_status_used >
                       levels_q[EIS_LVL_RXSTAT_LO +: EIS_LVL_WIDTH];  // [RULE_25]
   assign lvl_rise   = lvl_now & ~lvl_prev_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lvl_prev_q   <= 9'h000;
         timer_zero_q <= 1'b0;
      end else begin
         lvl_prev_q   <= lvl_now;
         timer_zero_q <= events.timer_count == EIS_TIMER_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Set vector; no enable gates any set term [RULE_23]
   always_comb begin
      set_v                    = EIS_ZERO_WORD;
      set_v[EIS_BIT_SOFTWARE]  = lvl_rise[0];                          // [RULE_02]
      set_v[EIS_BIT_TX_HALT]   = lvl_rise[1];                          // [RULE_03]
      set_v[EIS_BIT_RX_HALT]   = lvl_rise[2];                          // [RULE_04]
      set_v[EIS_BIT_DROP_MID]  = lvl_rise[3];                          // [RULE_05]
      set_v[EIS_BIT_TX_DONE]   = events.tx_buffer_loaded &&
                                 events.buffer_completion_marker;      // [RULE_06]
      set_v[EIS_BIT_RX_DMA]    = events.rx_dma_count_done;             // [RULE_07]
      set_v[EIS_BIT_TIMER]     = timer_zero_q &&
                                 (events.timer_count == EIS_TIMER_WRAP); // [RULE_08]
      set_v[EIS_BIT_WAKE]      = events.wake_event;                    // [RULE_10]
      set_v[EIS_BIT_TXS_OVF]   = events.tx_status_push &&
                                 events.tx_status_full;                // [RULE_13]
      set_v[EIS_BIT_OVERSIZE]  = events.rx_packet_end &&
                                 (events.rx_packet_bytes > EIS_OVERSIZE_BYTES); // [RULE_14]
      set_v[EIS_BIT_RX_FAULT]  = events.rx_fault;                      // [RULE_15]
      set_v[EIS_BIT_TX_FAULT]  = events.tx_fault;                      // [RULE_16]
      set_v[EIS_BIT_TXD_OVR]   = events.tx_data_write &&
                                 events.tx_data_full;                  // [RULE_17]
      set_v[EIS_BIT_TXD_SPACE] = lvl_rise[6];                          // [RULE_18]
      set_v[EIS_BIT_TXS_FULL]  = lvl_rise[4];                          // [RULE_19]
      set_v[EIS_BIT_TXS_LEVEL] = lvl_rise[7];                          // [RULE_19]
      set_v[EIS_BIT_DISCARD]   = events.frame_discarded;               // [RULE_20]
      set_v[EIS_BIT_RXS_FULL]  = lvl_rise[5];                          // [RULE_21]
      set_v[EIS_BIT_RXS_LEVEL] = lvl_rise[8];                          // [RULE_21]
      set_v[EIS_BIT_PIN_LO +: EIS_PIN_COUNT] = events.pin_events;      // [RULE_22]
   end

   // Only ones written to clearable positions clear [RULE_01] [RULE_10]
   assign clr_v = wr_status ? (hwdata & EIS_W1C_MASK) : EIS_ZERO_WORD;

   always_comb begin
      status_d              = (status_q & ~clr_v) | set_v; // [RULE_26]
      status_d              = status_d & EIS_W1C_MASK;
      status_d[EIS_BIT_PHY] = phy_sync_q;                  // [RULE_09]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_q <= EIS_ZERO_WORD;
      end else begin
         status_q <= status_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt indicators; the hold-off timer lives downstream, so the wake
   // flag gets its own line that the timer must not gate
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         master_irq_q <= 1'b0;
         wake_irq_q   <= 1'b0;
      end else begin
         master_irq_q <= |(status_q & enable_q);                           // [RULE_24]
         wake_irq_q   <= status_q[EIS_BIT_WAKE] && enable_q[EIS_BIT_WAKE]; // [RULE_12]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence sw_enable_rise;
      !enable_q[EIS_BIT_SOFTWARE] ##1 enable_q[EIS_BIT_SOFTWARE];
   endsequence

   sequence timer_wraps;
      (events.timer_count == EIS_TIMER_ZERO) ##1 (events.timer_count == EIS_TIMER_WRAP);
   endsequence

   sequence byte_test_write;
      wr_byte_test ##1 wake_request_q;
   endsequence

   chk_clear_on_one: assert property ( // [RULE_01]
      wr_status && hwdata[EIS_BIT_RX_HALT] && !set_v[EIS_BIT_RX_HALT]
      |=> !status_q[EIS_BIT_RX_HALT])
      else $error("flag survived a write of one");

   chk_zero_keeps: assert property ( // [RULE_01]
      wr_status && !hwdata[EIS_BIT_TIMER] && status_q[EIS_BIT_TIMER]
      |=> status_q[EIS_BIT_TIMER])
      else $error("flag lost on a write of zero");

   chk_software_set: assert property ( // [RULE_02]
      sw_enable_rise |=> status_q[EIS_BIT_SOFTWARE])
      else $error("software flag not set after trigger rise");

   chk_tx_halt_set: assert property ( // [RULE_03]
      $rose(events.tx_stop_requested && events.tx_halted) |=> status_q[EIS_BIT_TX_HALT])
      else $error("transmit halted flag missing");

   chk_drop_midpoint: assert property ( // [RULE_05]
      $rose(events.drop_count_msb) |=> status_q[EIS_BIT_DROP_MID])
      else $error("drop counter midpoint flag missing");

   chk_timer_wrap: assert property ( // [RULE_08]
      timer_wraps |=> status_q[EIS_BIT_TIMER])
      else $error("timer wrap flag missing");

   chk_phy_follow: assert property ( // [RULE_09]
      transceiver_irq_pin [*3] |=> status_q[EIS_BIT_PHY])
      else $error("transceiver bit does not follow its pin");

   chk_phy_unclear: assert property ( // [RULE_09]
      (!transceiver_irq_pin) [*3] |=> !status_q[EIS_BIT_PHY])
      else $error("transceiver bit high with pin low");

   chk_wake_write: assert property ( // [RULE_11]
      !wr_byte_test |=> !wake_request_q)
      else $error("wake request without byte-test write");

   chk_wake_pulse: assert property ( // [RULE_11]
      wr_byte_test |-> byte_test_write)
      else $error("byte-test write did not wake");

   chk_wake_bypass: assert property ( // [RULE_12]
      status_q[EIS_BIT_WAKE] && enable_q[EIS_BIT_WAKE] |=> wake_irq_q)
      else $error("wake interrupt delayed");

   chk_oversize: assert property ( // [RULE_14]
      events.rx_packet_end && (events.rx_packet_bytes > EIS_OVERSIZE_BYTES)
      |=> status_q[EIS_BIT_OVERSIZE])
      else $error("oversize flag missing");

   chk_master_irq: assert property ( // [RULE_24]
      (|(status_q & enable_q)) [*2] |-> master_irq_q)
      else $error("master indicator low with enabled flag");

   chk_master_quiet: assert property ( // [RULE_24]
      (status_q & enable_q) == EIS_ZERO_WORD |=> !master_irq_q)
      else $error("master indicator high with no enabled flag");

   chk_level_strict: assert property ( // [RULE_25]
      $rose(events.rx_status_used > levels_q[EIS_LVL_RXSTAT_LO +: EIS_LVL_WIDTH])
      |=> status_q[EIS_BIT_RXS_LEVEL])
      else $error("receive status level flag missing");

   chk_set_wins: assert property ( // [RULE_26]
      wr_status && hwdata[EIS_BIT_DISCARD] && events.frame_discarded
      |=> status_q[EIS_BIT_DISCARD])
      else $error("event lost against a clear");

   chk_rx_halt_set: assert property ( // [RULE_04]
      $rose(events.rx_halted) |=> status_q[EIS_BIT_RX_HALT])
      else $error("receive halted flag missing");

   chk_tx_done_set: assert property ( // [RULE_06]
      events.tx_buffer_loaded && events.buffer_completion_marker |=> status_q[EIS_BIT_TX_DONE])
      else $error("transmit done flag missing");

   chk_wake_set: assert property ( // [RULE_10]
      events.wake_event |=> status_q[EIS_BIT_WAKE])
      else $error("wake event flag missing");

   chk_txs_overflow: assert property ( // [RULE_13]
      events.tx_status_push && events.tx_status_full |=> status_q[EIS_BIT_TXS_OVF])
      else $error("status overflow flag missing");

   chk_data_overrun: assert property ( // [RULE_17]
      events.tx_data_write && events.tx_data_full |=> status_q[EIS_BIT_TXD_OVR])
      else $error("data overrun flag missing");

   chk_txs_full: assert property ( // [RULE_19]
      $rose(events.tx_status_full) |=> status_q[EIS_BIT_TXS_FULL])
      else $error("transmit status full flag missing");

   chk_discard_set: assert property ( // [RULE_20]
      events.frame_discarded |=> status_q[EIS_BIT_DISCARD])
      else $error("discard flag missing");

   chk_rxs_full: assert property ( // [RULE_21]
      $rose(events.rx_status_full) |=> status_q[EIS_BIT_RXS_FULL])
      else $error("receive status full flag missing");

   chk_pin_flags: assert property ( // [RULE_22]
      (|events.pin_events) |=>
      &(status_q[EIS_BIT_PIN_LO +: EIS_PIN_COUNT] | ~$past(events.pin_events)))
      else $error("pin event flag missing");

endmodule : eis_status

/* File: test/eis_host_model.sv */
// Host processor model: single-word AHB-Lite master for the register slave
`timescale 1ns/10ps

module eis_host_model
   import eis_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);

   initial begin
      hsel   = 1'b0;
      haddr  = EIS_ZERO_WORD;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'b010;
      hwdata = EIS_ZERO_WORD;
   end

   ////////////////////////////////////////////////////////////////////////////
   // No latency is assumed; the bound only stops a stuck slave hanging the run
   task automatic wait_ready(output logic ok);
      int n;
      ok = 1'b0;
      for (n = 0; n < 16 && !ok; n++) begin
         @(posedge clk);
         ok = (hready === 1'b1);
      end
   endtask : wait_ready

   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic ok);
      logic ok_a;
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= EIS_HTRANS_NONSEQ;
      haddr  <= {24'h00_0000, a};
      hwrite <= w;
      hsize  <= 3'b010;
      wait_ready(ok_a);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready(ok);
      r  = hrdata;
      ok = ok & ok_a;
   endtask : xfer

endmodule : eis_host_model

/* File: test/eis_status_tb.sv */
// Self-checking bench for the interrupt status block
`timescale 1ns/10ps

module eis_status_tb
   import eis_pkg::*;
;
   logic          clk;
   logic          rst;
   logic          hsel;
   logic [31:0]   haddr;
   logic [1:0]    htrans;
   logic          hwrite;
   logic [2:0]    hsize;
   logic [31:0]   hwdata;
   logic          hreadyout;
   logic          hresp;
   logic [31:0]   hrdata;
   eis_event_type ev;
   logic          phy_pin;
   logic          master_irq_q;
   logic          wake_irq_q;
   logic          wake_request_q;
   logic [31:0]   exp_status;
   logic [31:0]   exp_enable;
   logic [31:0]   r;
   logic [31:0]   lvl_word;
   int            err_count;
   int            comparisons;
   int            wake_pulses;
   int            bits[21] = '{25, 24, 23, 21, 20, 19, 17, 16, 15, 14, 13, 10, 9, 8, 7, 6,
                               4, 3, 2, 1, 0};

   eis_status dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .events(ev),
      .transceiver_irq_pin(phy_pin), .master_irq_q(master_irq_q), .wake_irq_q(wake_irq_q),
      .wake_request_q(wake_request_q));

   eis_host_model host_u (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   always @(posedge clk) begin
      if (wake_request_q === 1'b1) wake_pulses++;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] seen, input logic [31:0] expd);
      comparisons++;
      if (seen !== expd) begin
         err_count++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, expd);
      end
   endtask : check

   // Bus access plus the reference model of the status and enable registers
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      logic ok;
      host_u.xfer(a, w, d, r, ok);
      if (!ok) begin
         err_count++;
         test_done();
      end
      check({30'h0, hresp, hreadyout}, 32'h0000_0001);
      if (w && a == EIS_ADDR_STATUS) exp_status = exp_status & ~(d & EIS_W1C_MASK);
      if (w && a == EIS_ADDR_ENABLE) begin
         if (d[31] && !exp_enable[31]) exp_status[31] = 1'b1;
         exp_enable = d & EIS_ENABLE_MASK;
      end
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, EIS_ZERO_WORD);
      check(r, e);
      check({31'h0, master_irq_q}, {31'h0, |(exp_status & exp_enable)});
      check({31'h0, wake_irq_q}, {31'h0, exp_status[17] & exp_enable[17]});
   endtask : rd

   // Drives one source for one cycle; a level source then falls back to idle
   task automatic fire(input int b);
      @(posedge clk);
      case (b)
         25: begin
            ev.tx_stop_requested <= 1'b1;
            ev.tx_halted         <= 1'b1;
         end
         24: ev.rx_halted <= 1'b1;
         23: ev.drop_count_msb <= 1'b1;
         21: begin
            ev.tx_buffer_loaded         <= 1'b1;
            ev.buffer_completion_marker <= 1'b1;
         end
         20: ev.rx_dma_count_done <= 1'b1;
         19: ev.timer_count <= EIS_TIMER_WRAP;
         17: ev.wake_event <= 1'b1;
         16: begin
            ev.tx_status_push <= 1'b1;
            ev.tx_status_full <= 1'b1;
            exp_status[8] = 1'b1;
         end
         15: begin
            ev.rx_packet_end   <= 1'b1;
            ev.rx_packet_bytes <= EIS_OVERSIZE_BYTES + 16'h0001;
         end
         14: ev.rx_fault <= 1'b1;
         13: ev.tx_fault <= 1'b1;
         10: begin
            ev.tx_data_write <= 1'b1;
            ev.tx_data_full  <= 1'b1;
         end
         9: ev.tx_free_blocks <= 8'h49;
         8: ev.tx_status_full <= 1'b1;
         7: ev.tx_status_used <= 8'h01;
         6: ev.frame_discarded <= 1'b1;
         4: ev.rx_status_full <= 1'b1;
         3: ev.rx_status_used <= 8'h01;
         default: ev.pin_events[b] <= 1'b1;
      endcase
      @(posedge clk);
      ev <= '0;
      exp_status[b] = 1'b1;
   endtask : fire

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      ev = '0;
      phy_pin = 1'b0;
      exp_status = EIS_ZERO_WORD;
      exp_enable = EIS_ZERO_WORD;
      err_count = 0;
      comparisons = 0;
      wake_pulses = 0;
      void'($urandom(96));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(EIS_ADDR_STATUS, EIS_ZERO_WORD);
      rd(EIS_ADDR_LEVELS, EIS_LEVELS_RESET);
      rd(EIS_ADDR_BYTE_TEST, EIS_BYTE_TEST_VALUE);
      bus(8'h70, 1'b1, 32'hffff_ffff);
      rd(8'h70, EIS_ZERO_WORD);
      // Near misses: at threshold, exactly 2048 bytes, write or push while not full
      @(posedge clk);
      ev.tx_free_blocks   <= 8'h48;
      ev.rx_packet_end    <= 1'b1;
      ev.rx_packet_bytes  <= EIS_OVERSIZE_BYTES;
      ev.tx_data_write    <= 1'b1;
      ev.tx_status_push   <= 1'b1;
      ev.tx_halted        <= 1'b1;
      ev.tx_buffer_loaded <= 1'b1;
      @(posedge clk);
      ev <= '0;
      rd(EIS_ADDR_STATUS, EIS_ZERO_WORD);
      bus(EIS_ADDR_ENABLE, 1'b1, EIS_ZERO_WORD);
      bus(EIS_ADDR_ENABLE, 1'b1, $urandom | 32'h8000_0000);
      rd(EIS_ADDR_ENABLE, exp_enable);
      rd(EIS_ADDR_STATUS, exp_status);
      foreach (bits[i]) begin
         fire(bits[i]);
         rd(EIS_ADDR_STATUS, exp_status);
         bus(EIS_ADDR_STATUS, 1'b1, EIS_ZERO_WORD);
      end
      rd(EIS_ADDR_STATUS, exp_status);
      check(wake_pulses, 0);
      repeat (4) begin
         bus(EIS_ADDR_STATUS, 1'b1, $urandom);
         rd(EIS_ADDR_STATUS, exp_status);
      end
      // Transceiver bit follows its pin and ignores clears
      phy_pin <= 1'b1;
      repeat (4) @(posedge clk);
      exp_status[18] = 1'b1;
      bus(EIS_ADDR_STATUS, 1'b1, 32'hffff_ffff);
      rd(EIS_ADDR_STATUS, exp_status);
      phy_pin <= 1'b0;
      repeat (4) @(posedge clk);
      exp_status[18] = 1'b0;
      rd(EIS_ADDR_STATUS, exp_status);
      // Event in the data phase of its own clear keeps the flag
      bus(EIS_ADDR_ENABLE, 1'b1, 32'h0000_0040);
      fire(6);
      fork
         bus(EIS_ADDR_STATUS, 1'b1, 32'hffff_ffff);
         begin
            @(posedge clk);
            @(posedge clk);
            ev.frame_discarded <= 1'b1;
            @(posedge clk);
            ev.frame_discarded <= 1'b0;
         end
      join
      exp_status[6] = 1'b1;
      rd(EIS_ADDR_STATUS, exp_status);
      bus(EIS_ADDR_STATUS, 1'b1, 32'h0000_0040);
      rd(EIS_ADDR_STATUS, exp_status);
      // Only a byte-test write wakes the device; the host must make it
      bus(EIS_ADDR_BYTE_TEST, 1'b1, $urandom);
      repeat (3) @(posedge clk);
      check(wake_pulses, 1);
      rd(EIS_ADDR_BYTE_TEST, EIS_BYTE_TEST_VALUE);
      lvl_word = $urandom;
      bus(EIS_ADDR_LEVELS, 1'b1, lvl_word);
      rd(EIS_ADDR_LEVELS, lvl_word & EIS_LEVELS_MASK);
      test_done();
   end

endmodule : eis_status_tb
